//--- sdpe_encoder.v
// output pulse encoder of a differential speed sensor: edges in, width-coded pulses out
`timescale 1ns/1ps
`include "sdpe_defines.vh"
// Function
// - first pulse by second magnetic edge, only on a rising edge
// - hysteresis suppression active right from power-on
// - direction-based suppression active after two pulses, third full period
// - start-up may miss or lack direction for one period (three when weak)
// - after reversal at most one wrong-direction pulse, second is correct
// - low preamble of 30 us before every pulse rising edge
// - after preamble drive high for applicable width, then low
// - speed-only pulses until direction known, then direction-coded pulses
// - first pulse after power-on is 180 us high
// - direction pulses 90 us counter-clockwise, 45 us clockwise
module sdpe_encoder #(
   parameter CNT_W      = 16,
   parameter PRE_CYC    = `SDPE_PRE_LOW_CYC,
   parameter FIRST_CYC  = `SDPE_FIRST_CYC,
   parameter CCW_CYC    = `SDPE_CCW_CYC,
   parameter CW_CYC     = `SDPE_CW_CYC
) (
   input  wire i_mclk,
   input  wire i_rst_n,
   input  wire i_mag_edge,     // one-cycle pulse per magnetic transition
   input  wire i_mag_rising,   // polarity of that transition
   input  wire i_dir_valid,    // front end has a direction estimate
   input  wire i_dir_ccw,      // estimated direction, 1 = counter-clockwise
   output reg  o_cur_high,     // 1 = high current level on the line
   output reg  o_busy,         // pulse frame in progress
   output reg  o_dir_mode,     // a direction-coded frame has started since reset; sticky even when later pulses are speed-only
   output reg  o_dir_supp_on   // direction-based vibration suppression active
);
   // frame states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_PRE  = 2'b01;
   localparam [1:0] ST_HIGH = 2'b10;
   // width selectors latched per frame
   localparam [1:0] W_FIRST = 2'b00;
   localparam [1:0] W_CCW   = 2'b01;
   localparam [1:0] W_CW    = 2'b10;
   // saturation points of the start-up counters
   localparam [1:0] PULSE_SAT  = 2'b11;
   localparam [2:0] PERIOD_SAT = 3'b111;

   // frame registers
   reg [1:0]       state_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg [1:0]       wsel_ff;
   reg             first_done_ff;

   // start-up registers
   reg [1:0]       pulse_cnt_ff;
   reg [2:0]       period_cnt_ff;

   // next values of the frame registers
   reg [1:0]       nxt_state;
   reg [CNT_W-1:0] nxt_cnt;
   reg [1:0]       nxt_wsel;
   reg             nxt_first_done;
   reg             nxt_cur_high;
   reg             nxt_busy;

   // next values of the start-up and mode registers
   reg [1:0]       nxt_pulse_cnt;
   reg [2:0]       nxt_period_cnt;
   reg             nxt_dir_supp_on;
   reg             nxt_dir_mode;

   // width lookup, one entry per selector; anything unknown falls back
   // to the long first-pulse width, the safest reading for the receiver
   function [CNT_W-1:0] sdpe_width;
      input [1:0] sel;
      begin
         case (sel)
            W_CCW:   sdpe_width = CCW_CYC[CNT_W-1:0];
            W_CW:    sdpe_width = CW_CYC[CNT_W-1:0];
            default: sdpe_width = FIRST_CYC[CNT_W-1:0];
         endcase
      end
   endfunction

   // timer load: a span of n cycles is loaded as n-1 and runs down to zero
   function [CNT_W-1:0] sdpe_load;
      input [CNT_W-1:0] cycles;
      begin
         sdpe_load = cycles - 1'b1;
      end
   endfunction

   // the hysteresis stage in the front end is live from power-on, so every
   // edge arriving here is already filtered; the first pulse waits for a
   // rising edge, later edges of either polarity trigger
   wire       trig      = i_mag_edge && (first_done_ff || i_mag_rising);
   // a trigger is only taken while no frame is running
   wire       start     = trig && (state_ff == ST_IDLE);
   // direction usable once suppression is on and the front end has an estimate
   wire       use_dir   = o_dir_supp_on && i_dir_valid;
   // width for the frame a trigger would open; the estimate is taken fresh at
   // every trigger, so a stale estimate at a reversal spoils one pulse at most
   wire [1:0] trig_wsel = !first_done_ff ? W_FIRST :
                          !use_dir ? W_FIRST :
                          (i_dir_ccw ? W_CCW : W_CW);
   // shared timer expiry and end-of-frame decode
   wire       cnt_done  = (cnt_ff == {CNT_W{1'b0}});
   wire       frame_end = (state_ff == ST_HIGH) && cnt_done;

   // pulse frame machine, one frame per accepted magnetic edge:
   //   edge taken -> busy rises, line held low for the preamble
   //   preamble expired -> line driven high for the latched width
   //   width expired -> line low, busy low, next edge may be taken at once
   // edges arriving mid-frame are dropped so frames never overlap, which the
   // 12 kHz / 8 kHz limits guarantee in normal operation; a faster wheel
   // therefore loses pulses rather than corrupting them
   always @* begin
      // hold everything unless a state below moves it
      nxt_state      = state_ff;
      nxt_cnt        = cnt_ff;
      nxt_wsel       = wsel_ff;
      nxt_first_done = first_done_ff;
      nxt_cur_high   = o_cur_high;
      nxt_busy       = o_busy;
      case (state_ff)
         ST_IDLE: begin
            if (trig) begin
               nxt_state = ST_PRE;
               nxt_cnt   = sdpe_load(PRE_CYC[CNT_W-1:0]);
               nxt_wsel  = trig_wsel;
               nxt_busy  = 1'b1;
            end
         end
         ST_PRE: begin
            if (cnt_done) begin
               nxt_state    = ST_HIGH;
               nxt_cnt      = sdpe_load(sdpe_width(wsel_ff));
               nxt_cur_high = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         ST_HIGH: begin
            if (cnt_done) begin
               nxt_state      = ST_IDLE;
               nxt_cur_high   = 1'b0;
               nxt_busy       = 1'b0;
               nxt_first_done = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - 1'b1;
            end
         end
         default: begin
            // unused code: recover to idle with the line low
            nxt_state    = ST_IDLE;
            nxt_cur_high = 1'b0;
            nxt_busy     = 1'b0;
         end
      endcase
   end

   // start-up counters: two completed pulses plus a third full period (three
   // rising edges) enable direction suppression; both counters saturate so a
   // long run cannot wrap them back into the start-up window
   // rising edges are counted even mid-frame, since the magnet keeps turning
   always @* begin
      // hold by default
      nxt_pulse_cnt   = pulse_cnt_ff;
      nxt_period_cnt  = period_cnt_ff;
      nxt_dir_supp_on = o_dir_supp_on;
      if (frame_end && pulse_cnt_ff != PULSE_SAT)
         nxt_pulse_cnt = pulse_cnt_ff + 2'b01;
      if (i_mag_edge && i_mag_rising && period_cnt_ff != PERIOD_SAT)
         nxt_period_cnt = period_cnt_ff + 3'b001;
      if (pulse_cnt_ff >= `SDPE_DIR_STARTUP_COUNT && period_cnt_ff >= `SDPE_DIR_STARTUP_RISES)
         nxt_dir_supp_on = 1'b1;
   end

   // direction mode starts with the first direction-coded frame; it never
   // drops back, since it holds its own value and only reset clears it
   always @* begin
      nxt_dir_mode = o_dir_mode;
      if (start && use_dir)
         nxt_dir_mode = 1'b1;
   end

   // frame registers; outputs come straight from these flip-flops
   always @(posedge i_mclk) begin
      if (!i_rst_n) begin
         state_ff      <= ST_IDLE;
         cnt_ff        <= {CNT_W{1'b0}};
         wsel_ff       <= W_FIRST;
         first_done_ff <= 1'b0;
         o_cur_high    <= 1'b0;
         o_busy        <= 1'b0;
      end else begin
         state_ff      <= nxt_state;
         cnt_ff        <= nxt_cnt;
         wsel_ff       <= nxt_wsel;
         first_done_ff <= nxt_first_done;
         o_cur_high    <= nxt_cur_high;
         o_busy        <= nxt_busy;
      end
   end

   // start-up registers; suppression state is cleared only by reset
   always @(posedge i_mclk) begin
      if (!i_rst_n) begin
         pulse_cnt_ff  <= 2'b00;
         period_cnt_ff <= 3'b000;
         o_dir_supp_on <= 1'b0;
      end else begin
         pulse_cnt_ff  <= nxt_pulse_cnt;
         period_cnt_ff <= nxt_period_cnt;
         o_dir_supp_on <= nxt_dir_supp_on;
      end
   end

   // direction-mode flag, sticky until reset
   always @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_dir_mode <= 1'b0;
      end else begin
         o_dir_mode <= nxt_dir_mode;
      end
   end
endmodule // sdpe_encoder

//--- sdpe_defines.vh
// timing constants and start-up counts for the speed/direction pulse encoder
`ifndef SDPE_DEFINES_VH
`define SDPE_DEFINES_VH
`define SDPE_CLK_MHZ                 40
`define SDPE_PRE_LOW_US              30
`define SDPE_FIRST_PULSE_US          180
`define SDPE_CCW_PULSE_US            90
`define SDPE_CW_PULSE_US             45
`define SDPE_PRE_LOW_CYC             (`SDPE_PRE_LOW_US * `SDPE_CLK_MHZ)
`define SDPE_FIRST_CYC               (`SDPE_FIRST_PULSE_US * `SDPE_CLK_MHZ)
`define SDPE_CCW_CYC                 (`SDPE_CCW_PULSE_US * `SDPE_CLK_MHZ)
`define SDPE_CW_CYC                  (`SDPE_CW_PULSE_US * `SDPE_CLK_MHZ)
`define SDPE_HYST_STARTUP_COUNT      0
`define SDPE_DIR_STARTUP_COUNT       2
`define SDPE_DIR_STARTUP_RISES       3
`define SDPE_STARTUP_MISS_PERIODS    1
`define SDPE_INVALID_AFTER_REV       1
`define SDPE_CW_MAX_RATE_HZ          12000
`define SDPE_CCW_MAX_RATE_HZ         8000
`endif

//--- sdpe_assertions.sv
// checker for the pulse encoder outputs
`timescale 1ns/1ps
module sdpe_chk #(parameter int PRE_CYC = 4, FIRST_CYC = 24, CCW_CYC = 12, CW_CYC = 6) (
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_mag_edge,
   input wire i_mag_rising,
   input wire i_dir_valid,
   input wire i_dir_ccw,
   input wire o_cur_high,
   input wire o_busy,
   input wire o_dir_mode,
   input wire o_dir_supp_on);
   int       hi_ff, exp_ff;
   reg [1:0] np_ff;
   // high-phase length, completed pulses, width owed by the pending pulse
   always @(posedge i_mclk) begin
      hi_ff <= o_cur_high ? hi_ff + 1 : 0;
      np_ff <= !i_rst_n ? 2'h0 : ($fell(o_busy) && np_ff != 2'h3) ? np_ff + 2'h1 : np_ff;
      if (i_mag_edge && !o_busy) begin
         exp_ff <= (o_dir_supp_on && i_dir_valid) ? (i_dir_ccw ? CCW_CYC : CW_CYC) : FIRST_CYC;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_pulse_cause: assert property ($rose(o_busy) |-> $past(i_mag_edge)) else $error("no edge");
   a_first_rising: assert property ($rose(o_busy) && np_ff == 2'h0 |-> $past(i_mag_rising))
      else $error("first pulse on falling edge");
   a_pre_low: assert property ($rose(o_cur_high) |-> $past(o_busy, PRE_CYC)
      && !$past(o_busy, PRE_CYC + 1)) else $error("preamble length wrong");
   a_first_width: assert property ($fell(o_cur_high) && np_ff == 2'h0 |-> hi_ff == FIRST_CYC)
      else $error("first width wrong");
   a_coded_width: assert property ($fell(o_cur_high) |-> hi_ff == exp_ff) else $error("width");
   a_end_together: assert property ($fell(o_cur_high) |-> $fell(o_busy)) else $error("end");
   a_no_overlap: assert property (o_cur_high |-> o_busy) else $error("high outside frame");
   a_supp_late: assert property ($rose(o_dir_supp_on) |-> np_ff >= 2'h2) else $error("early");
   a_supp_sticky: assert property (o_dir_supp_on |=> o_dir_supp_on) else $error("supp lost");
   a_mode_cause: assert property ($rose(o_dir_mode) |-> o_busy && o_dir_supp_on) else $error("m");
endmodule // sdpe_chk
bind sdpe_encoder sdpe_chk #(.PRE_CYC(PRE_CYC), .FIRST_CYC(FIRST_CYC), .CCW_CYC(CCW_CYC),
   .CW_CYC(CW_CYC)) i_sdpe_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mag_edge(i_mag_edge),
   .i_mag_rising(i_mag_rising), .i_dir_valid(i_dir_valid), .i_dir_ccw(i_dir_ccw),
   .o_cur_high(o_cur_high), .o_busy(o_busy), .o_dir_mode(o_dir_mode),
   .o_dir_supp_on(o_dir_supp_on));

//--- sdpe_tcu_model.sv
// line receiver model: classifies each high phase by its width
`timescale 1ns/1ps
module sdpe_tcu_model #(parameter int CCW_CYC = 12, CW_CYC = 6) (
   input  wire       i_mclk,
   input  wire       i_cur_high,
   output reg  [1:0] o_class,    // 0 speed, 1 ccw, 2 cw
   output reg  [7:0] o_pulses);
   int w = 0;
   // thresholds halfway between nominal widths tolerate timer slack
   always @(posedge i_mclk) begin
      w <= i_cur_high ? w + 1 : 0;
      if (!i_cur_high && w != 0) begin
         o_pulses <= o_pulses + 8'h01;
         o_class  <= w < (CW_CYC + CCW_CYC) / 2 ? 2'h2 : w < CCW_CYC * 3 / 2 ? 2'h1 : 2'h0;
      end
   end
   initial o_pulses = 8'h00;
endmodule // sdpe_tcu_model

//--- speed_direction_pulse_encoder_test.sv
// self-checking bench for the pulse encoder with a line receiver model
`timescale 1ns/1ps
module speed_direction_pulse_encoder_test;
   reg i_mclk, i_rst_n, i_mag_edge, i_mag_rising, i_dir_valid, i_dir_ccw;
   wire o_cur_high, o_busy, o_dir_mode, o_dir_supp_on;
   wire [1:0] rx_class;
   wire [7:0] rx_pulses;
   int err_count, samples_checked;
   // rows: rising, valid, ccw, expected class; third rising edge still gives a speed pulse
   reg [4:0] rows [0:5] = '{5'h10, 5'h1C, 5'h1C, 5'h0D, 5'h1A, 5'h00};
   sdpe_encoder #(.PRE_CYC(4), .FIRST_CYC(24), .CCW_CYC(12), .CW_CYC(6)) i_sdpe_encoder (
      .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_mag_edge(i_mag_edge), .i_mag_rising(i_mag_rising),
      .i_dir_valid(i_dir_valid), .i_dir_ccw(i_dir_ccw), .o_cur_high(o_cur_high),
      .o_busy(o_busy), .o_dir_mode(o_dir_mode), .o_dir_supp_on(o_dir_supp_on));
   sdpe_tcu_model i_sdpe_tcu_model (.i_mclk(i_mclk),
      .i_cur_high(o_cur_high), .o_class(rx_class), .o_pulses(rx_pulses));
   task automatic check(input [7:0] got, input [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one-cycle edge strobe, driven on the falling clock edge
   task automatic edge_in(input [2:0] v);
      @(negedge i_mclk) {i_mag_rising, i_dir_valid, i_dir_ccw} = v;
      i_mag_edge = 1'b1;
      @(negedge i_mclk) i_mag_edge = 1'b0;
   endtask
   task automatic wait_idle;
      repeat (200) if (o_busy !== 1'b0) @(negedge i_mclk);
      repeat (2) @(negedge i_mclk);
   endtask
   // reset for two cycles, then a falling first edge must not start a pulse
   task automatic do_reset;
      i_rst_n = 1'b0;
      repeat (2) @(negedge i_mclk);
      i_rst_n = 1'b1;
      check({o_cur_high, o_busy, o_dir_mode, o_dir_supp_on}, 8'h00);
      edge_in(3'h3);
      check(o_busy, 8'h00);
   endtask
   task automatic final_report;
      $display("checked %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   // watchdog well beyond the few microseconds the sequence needs
   initial begin
      #100000;
      err_count++;
      final_report();
   end
   initial begin
      {i_mag_edge, i_mag_rising, i_dir_valid, i_dir_ccw} = 4'h0;
      do_reset();
      for (int i = 0; i < 6; i++) begin
         edge_in(rows[i][4:2]);
         wait_idle();
         check(rx_class, rows[i][1:0]);
      end
      check({o_dir_mode, o_dir_supp_on}, 8'h03);
      // second edge lands mid-frame and must be dropped
      edge_in(3'h6);
      edge_in(3'h4);
      wait_idle();
      check(rx_pulses, 8'h07);
      // mid-run reset: start-up state clears, first pulse is speed-only again
      do_reset();
      edge_in(3'h7);
      wait_idle();
      check(rx_class, 8'h00);
      check(rx_pulses, 8'h08);
      check({o_dir_mode, o_dir_supp_on}, 8'h00);
      final_report();
   end
endmodule // speed_direction_pulse_encoder_test
